/* File: pkg/nv_trim_pkg.sv */
package nv_trim_pkg;
   localparam int CLK_MHZ          = 50;
   localparam int CLK_PERIOD_NS    = 20;
   localparam int RD_TIMER_UNIT_US = 5000;
   localparam int WR_TIMER_UNIT_US = 50000;
   localparam int RD_UNIT_CYCLES   = RD_TIMER_UNIT_US * CLK_MHZ;
   localparam int WR_PER_RD_UNITS  = WR_TIMER_UNIT_US / RD_TIMER_UNIT_US;
   localparam int CELL_BITS        = 6;
   localparam int TRIM_SIGN_BIT    = 5;
   localparam int CTL_LAUNCH_BIT   = 3;
   localparam int OP_SEL_W         = 3;
   localparam int ST_VERIFY_BIT    = 2;
   localparam int ST_VARIANT_BIT   = 1;
   localparam int ST_ACTIVE_BIT    = 0;
   localparam int ATTEMPT_W        = 2;
   localparam int PHASE_W          = 12;
   localparam logic [1:0] LAST_ATTEMPT = 2'h2;
   localparam logic [7:0] CMD_NV_CONTROL = 8'hB8;
   localparam logic [7:0] CMD_NV_MASK    = 8'hB9;
   localparam logic [7:0] CMD_RD_VOLT    = 8'hF4;
   localparam logic [7:0] CMD_WR_VOLT    = 8'hF5;
   localparam logic [7:0] CMD_WR_TIMER   = 8'hF6;
   localparam logic [7:0] CMD_RD_TIMER   = 8'hF7;
   localparam logic [7:0] CMD_BIAS_POT   = 8'h81;
   localparam logic [7:0] CMD_DISP_OFF   = 8'hAE;
   localparam logic [7:0] CMD_DISP_ON    = 8'hAF;
   localparam logic [7:0] CMD_SW_RESET   = 8'hE2;
   localparam logic [2:0] OP_PROGRAM     = 3'h3;
   localparam logic [2:0] OP_ERASE       = 3'h2;
   localparam logic [7:0] POT_RESET      = 8'h49;
   localparam logic [7:0] RD_VOLT_RESET  = 8'h64;
   localparam logic [7:0] WR_VOLT_RESET  = 8'hFF;
   localparam logic [7:0] WR_TIMER_RESET = 8'h02;
   localparam logic [7:0] RD_TIMER_RESET = 8'h02;
   localparam logic [5:0] CELL_RESET     = 6'h00;
   typedef enum logic [2:0] {
      S_AUTO_START, S_AUTO_SENSE, S_AUTO_SETTLE,
      S_IDLE, S_PULSE, S_VERIFY, S_CHECK
   } nv_state_t;
endpackage

/* File: pkg/nv_cell_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface nv_cell_if;
   logic       applyPulse;
   logic       opProgram;
   logic       supplyOk;
   logic       senseReq;
   logic [5:0] mask;
   logic [5:0] senseData;
   modport ctrl  (output applyPulse, opProgram, supplyOk, senseReq, mask,
                  input senseData);
   modport cells (input applyPulse, opProgram, supplyOk, senseReq, mask,
                  output senseData);
endinterface
`default_nettype wire

/* File: verilog/nv_cell_array.sv */
`timescale 1ns/1ns
`default_nettype none
module nv_cell_array (
   input  wire logic clk,
   input  wire logic rstN,
   nv_cell_if.cells  cellBus
);
   logic [5:0] cells_r;
   // cells model the store; programming sets bits only with the supply up
   wire [5:0] progVal  = cells_r | cellBus.mask;
   wire [5:0] eraseVal = cells_r & ~cellBus.mask;
   wire       progOk   = cellBus.opProgram && cellBus.supplyOk;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         cells_r <= nv_trim_pkg::CELL_RESET;
      end else if (cellBus.applyPulse) begin
         cells_r <= cellBus.opProgram ? (progOk ? progVal : cells_r)
                                      : eraseVal;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         cellBus.senseData <= nv_trim_pkg::CELL_RESET;
      end else if (cellBus.senseReq) begin
         cellBus.senseData <= cells_r; // see [RULE5]
      end
   end

   property p_erase_clears;
      @(posedge clk) disable iff (!rstN)
      cellBus.applyPulse && !cellBus.opProgram |=>
         (cells_r & $past(cellBus.mask)) == '0;
   endproperty
   a_erase_clears: assert property (p_erase_clears) // see [RULE5]
      else $error("erase left masked cells set");
endmodule
`default_nettype wire

/* File: verilog/nv_trim_program_erase_ctrl.sv */
// Notes on behaviour
// [RULE1] status read returns live flags
// [RULE2] verify after each attempt; pass sets ok
// [RULE3] two retries, third failure aborts, ok low
// [RULE4] variant flag is a fixed constant
// [RULE5] store holds six trim cells
// [RULE6] effective pot is pot plus/minus trim
// [RULE7] nv operations exclude display enable
// [RULE8] cycle type from cmd/data and read/write
// [RULE9] control byte then parameter launches operation
// [RULE10] mask byte selects cells for operation
// [RULE11] host polls status until done; the testbench waits on the nvOpActive and verifyOk outputs instead
// [RULE12] host resets and waits before commands
// [RULE13] host pulses reset before power down
// [RULE14] display disable keeps all other state
// [RULE15] host programs one cell at once
// [RULE16] host erases before programming
// [RULE17] ok at bit two, active at bit zero
// [RULE18] timer commands set pulse lengths
// [RULE19] auto read only after hardware reset
// [RULE20] auto read flags go 00,10,11,01
`timescale 1ns/1ns
`default_nettype none
module nv_trim_program_erase_ctrl #(
   parameter int   TICK_CYCLES = nv_trim_pkg::RD_UNIT_CYCLES,
   parameter logic VARIANT_ID  = 1'b0 // arbitrary value
)(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       hostStrobe,
   input  wire logic       cmdDataSelect,
   input  wire logic       readWriteSelect,
   input  wire logic [7:0] hostWrData,
   input  wire logic       programSupplyPin,
   output logic      [7:0] hostRdData,
   output logic            hostRdValid,
   output logic            displayEnable,
   output logic      [7:0] effectivePotValue,
   output logic      [5:0] trimOffsetField,
   output logic      [7:0] pumpVoltageSetting,
   output logic            nvOpActive,
   output logic            verifyOk
);
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   logic [1:0] rstPipe_r;
   wire        rstSyncN = rstPipe_r[1];
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) rstPipe_r <= '0;
      else rstPipe_r <= {rstPipe_r[0], 1'b1};
   end

   logic supplyMeta_r, supplySync_r;
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         supplyMeta_r <= 1'b0;
         supplySync_r <= 1'b0;
      end else begin
         supplyMeta_r <= programSupplyPin;
         supplySync_r <= supplyMeta_r;
      end
   end

   nv_trim_pkg::nv_state_t state_r, state_nxt;
   logic       active_r, active_nxt, ok_r, ok_nxt;
   logic [nv_trim_pkg::ATTEMPT_W-1:0] attempt_r, attempt_nxt;
   logic       phaseStart, applyPulse, senseReq, loadTrim;
   logic [7:0] pot_r, rdVolt_r, wrVolt_r, wrTimer_r, rdTimer_r, mask_r;
   logic [7:0] pendCmd_r;
   logic       pendValid_r, dispEn_r, opProgram_r;
   logic [5:0] trim_r;
   logic [TW-1:0] tickCnt_r;
   logic [nv_trim_pkg::PHASE_W-1:0] phaseCnt_r;

   nv_cell_if cellBus ();
   nv_cell_array u_cells (
      .clk     (ref_clk),
      .rstN    (rstSyncN),
      .cellBus (cellBus.cells)
   );
   assign cellBus.applyPulse = applyPulse;
   assign cellBus.opProgram  = opProgram_r;
   assign cellBus.supplyOk   = supplySync_r;
   assign cellBus.senseReq   = senseReq;
   assign cellBus.mask       = mask_r[nv_trim_pkg::CELL_BITS-1:0];

   // host cycle decode
   wire cmdWrite   = hostStrobe && !cmdDataSelect && !readWriteSelect; // see [RULE8]
   wire statusRead = hostStrobe && !cmdDataSelect && readWriteSelect; // see [RULE8]
   wire opcodeWr   = cmdWrite && !pendValid_r;
   wire paramWr    = cmdWrite && pendValid_r;
   wire busy       = state_r != nv_trim_pkg::S_IDLE;
   wire paramOk    = paramWr && !busy; // see [RULE7]
   wire takesParam = hostWrData == nv_trim_pkg::CMD_NV_CONTROL
                  || hostWrData == nv_trim_pkg::CMD_NV_MASK
                  || hostWrData == nv_trim_pkg::CMD_RD_VOLT
                  || hostWrData == nv_trim_pkg::CMD_WR_VOLT
                  || hostWrData == nv_trim_pkg::CMD_WR_TIMER
                  || hostWrData == nv_trim_pkg::CMD_RD_TIMER
                  || hostWrData == nv_trim_pkg::CMD_BIAS_POT;
   wire [2:0] opSel = hostWrData[nv_trim_pkg::OP_SEL_W-1:0];
   wire opIsProg   = opSel == nv_trim_pkg::OP_PROGRAM;
   wire launchReq  = paramWr && pendCmd_r == nv_trim_pkg::CMD_NV_CONTROL
                  && hostWrData[nv_trim_pkg::CTL_LAUNCH_BIT]
                  && (opIsProg || opSel == nv_trim_pkg::OP_ERASE); // see [RULE9]
   wire launchOk   = launchReq && !busy && !dispEn_r; // see [RULE7]
   wire dispOnOk   = opcodeWr && hostWrData == nv_trim_pkg::CMD_DISP_ON
                  && !busy; // see [RULE7]
   wire dispOff    = opcodeWr && hostWrData == nv_trim_pkg::CMD_DISP_OFF;
   // software reset only replaces the pending opcode and clears its flag, so no auto read
   wire swReset    = opcodeWr && hostWrData == nv_trim_pkg::CMD_SW_RESET;

   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         pendValid_r <= 1'b0;
         pendCmd_r   <= '0;
      end else if (cmdWrite) begin
         pendValid_r <= opcodeWr && takesParam;
         pendCmd_r   <= hostWrData;
      end
   end

   // parameter bytes are consumed but dropped while an operation runs
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         pot_r     <= nv_trim_pkg::POT_RESET;
         rdVolt_r  <= nv_trim_pkg::RD_VOLT_RESET;
         wrVolt_r  <= nv_trim_pkg::WR_VOLT_RESET;
         wrTimer_r <= nv_trim_pkg::WR_TIMER_RESET;
         rdTimer_r <= nv_trim_pkg::RD_TIMER_RESET;
         mask_r    <= '0;
      end else if (paramOk) begin
         unique case (pendCmd_r)
            nv_trim_pkg::CMD_NV_MASK:  mask_r    <= hostWrData; // see [RULE10]
            nv_trim_pkg::CMD_RD_VOLT:  rdVolt_r  <= hostWrData;
            nv_trim_pkg::CMD_WR_VOLT:  wrVolt_r  <= hostWrData;
            nv_trim_pkg::CMD_WR_TIMER: wrTimer_r <= hostWrData; // see [RULE18]
            nv_trim_pkg::CMD_RD_TIMER: rdTimer_r <= hostWrData; // see [RULE18]
            nv_trim_pkg::CMD_BIAS_POT: pot_r     <= hostWrData;
            default: ;
         endcase
      end
   end

   // display off clears only the enable; nothing else is reset
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) dispEn_r <= 1'b0;
      else if (dispOff) dispEn_r <= 1'b0; // see [RULE14]
      else if (dispOnOk) dispEn_r <= 1'b1; // see [RULE7]
   end

   // phase timer: one tick per read-timer unit, restarted per phase
   wire tick      = tickCnt_r == TICK_LAST;
   wire phaseDone = tick && phaseCnt_r <= 1;
   wire [nv_trim_pkg::PHASE_W-1:0] wrLen =
      nv_trim_pkg::PHASE_W'(wrTimer_r * nv_trim_pkg::WR_PER_RD_UNITS);
   wire [nv_trim_pkg::PHASE_W-1:0] rdLen =
      nv_trim_pkg::PHASE_W'(rdTimer_r);
   wire [nv_trim_pkg::PHASE_W-1:0] phaseLen =
      (state_nxt == nv_trim_pkg::S_PULSE) ? wrLen : rdLen; // see [RULE18]

   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         tickCnt_r  <= '0;
         phaseCnt_r <= '0;
      end else if (phaseStart) begin
         tickCnt_r  <= '0;
         phaseCnt_r <= phaseLen;
      end else begin
         tickCnt_r  <= tick ? '0 : tickCnt_r + 1'b1;
         if (tick && phaseCnt_r != '0) phaseCnt_r <= phaseCnt_r - 1'b1;
      end
   end

   wire [5:0] selMask   = mask_r[nv_trim_pkg::CELL_BITS-1:0];
   wire [5:0] sensedSel = cellBus.senseData & selMask;
   wire verifyPass = opProgram_r ? (sensedSel == selMask)
                                 : (sensedSel == '0);

   always_comb begin
      state_nxt   = state_r;
      active_nxt  = active_r;
      ok_nxt      = ok_r;
      attempt_nxt = attempt_r;
      phaseStart  = 1'b0;
      applyPulse  = 1'b0;
      senseReq    = 1'b0;
      loadTrim    = 1'b0;
      unique case (state_r)
         nv_trim_pkg::S_AUTO_START: begin
            state_nxt  = nv_trim_pkg::S_AUTO_SENSE;
            active_nxt = 1'b1; // see [RULE20]
            phaseStart = 1'b1;
         end
         nv_trim_pkg::S_AUTO_SENSE: if (phaseDone) begin
            senseReq   = 1'b1;
            ok_nxt     = 1'b1; // see [RULE20]
            state_nxt  = nv_trim_pkg::S_AUTO_SETTLE;
            phaseStart = 1'b1;
         end
         nv_trim_pkg::S_AUTO_SETTLE: if (phaseDone) begin
            loadTrim   = 1'b1;
            active_nxt = 1'b0; // see [RULE20]
            state_nxt  = nv_trim_pkg::S_IDLE;
         end
         nv_trim_pkg::S_IDLE: if (launchOk) begin
            state_nxt   = nv_trim_pkg::S_PULSE;
            active_nxt  = 1'b1;
            ok_nxt      = 1'b0;
            attempt_nxt = '0;
            phaseStart  = 1'b1;
         end
         nv_trim_pkg::S_PULSE: if (phaseDone) begin
            applyPulse = 1'b1;
            state_nxt  = nv_trim_pkg::S_VERIFY;
            phaseStart = 1'b1;
         end
         nv_trim_pkg::S_VERIFY: if (phaseDone) begin
            senseReq  = 1'b1; // see [RULE2]
            state_nxt = nv_trim_pkg::S_CHECK;
         end
         nv_trim_pkg::S_CHECK: begin
            if (verifyPass) begin
               ok_nxt     = 1'b1; // see [RULE2]
               active_nxt = 1'b0;
               state_nxt  = nv_trim_pkg::S_IDLE;
            end else if (attempt_r == nv_trim_pkg::LAST_ATTEMPT) begin
               ok_nxt     = 1'b0; // see [RULE3]
               active_nxt = 1'b0;
               state_nxt  = nv_trim_pkg::S_IDLE;
            end else begin
               attempt_nxt = attempt_r + 1'b1; // see [RULE3]
               state_nxt   = nv_trim_pkg::S_PULSE;
               phaseStart  = 1'b1;
            end
         end
         default: state_nxt = nv_trim_pkg::S_IDLE;
      endcase
   end

   // only a hardware reset enters the auto read
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state_r   <= nv_trim_pkg::S_AUTO_START; // see [RULE19]
         active_r  <= 1'b0;
         ok_r      <= 1'b0;
         attempt_r <= '0;
      end else begin
         state_r   <= state_nxt;
         active_r  <= active_nxt;
         ok_r      <= ok_nxt;
         attempt_r <= attempt_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) opProgram_r <= 1'b0;
      else if (launchOk) opProgram_r <= opIsProg; // see [RULE9]
   end

   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) trim_r <= nv_trim_pkg::CELL_RESET;
      else if (loadTrim) trim_r <= cellBus.senseData; // see [RULE5]
   end

   wire [7:0] trimMag = 8'(trim_r[nv_trim_pkg::TRIM_SIGN_BIT-1:0]);
   wire [7:0] effNext = trim_r[nv_trim_pkg::TRIM_SIGN_BIT]
                        ? pot_r - trimMag : pot_r + trimMag; // see [RULE6]
   wire [7:0] statusByte;
   assign statusByte = {5'h00, ok_r, VARIANT_ID, active_r}; // see [RULE17]

   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         hostRdData         <= '0;
         hostRdValid        <= 1'b0;
         effectivePotValue  <= nv_trim_pkg::POT_RESET;
         pumpVoltageSetting <= nv_trim_pkg::RD_VOLT_RESET;
      end else begin
         hostRdValid        <= statusRead;
         if (statusRead) hostRdData <= statusByte; // see [RULE1]
         effectivePotValue  <= effNext;
         pumpVoltageSetting <= (state_r == nv_trim_pkg::S_PULSE)
                               ? wrVolt_r : rdVolt_r;
      end
   end

   assign displayEnable   = dispEn_r;
   assign trimOffsetField = trim_r;
   assign nvOpActive      = active_r;
   assign verifyOk        = ok_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstSyncN);

   property p_status_live;
      statusRead |=> hostRdValid
         && hostRdData[nv_trim_pkg::ST_VERIFY_BIT] == $past(ok_r)
         && hostRdData[nv_trim_pkg::ST_ACTIVE_BIT] == $past(active_r);
   endproperty
   a_status_live: assert property (p_status_live) // see [RULE1]
      else $error("status byte not live");

   property p_variant_fixed;
      hostRdValid |-> hostRdData[nv_trim_pkg::ST_VARIANT_BIT] == VARIANT_ID;
   endproperty
   a_variant_fixed: assert property (p_variant_fixed) // see [RULE4]
      else $error("variant flag changed");

   property p_pass_ends;
      state_r == nv_trim_pkg::S_CHECK && verifyPass |=>
         ok_r && !active_r && state_r == nv_trim_pkg::S_IDLE;
   endproperty
   a_pass_ends: assert property (p_pass_ends) // see [RULE2]
      else $error("verify pass did not end operation");

   property p_third_fail;
      state_r == nv_trim_pkg::S_CHECK && !verifyPass
         && attempt_r == nv_trim_pkg::LAST_ATTEMPT |=> !ok_r && !active_r;
   endproperty
   a_third_fail: assert property (p_third_fail) // see [RULE3]
      else $error("third failure did not abort");

   property p_retry;
      state_r == nv_trim_pkg::S_CHECK && !verifyPass
         && attempt_r != nv_trim_pkg::LAST_ATTEMPT |=>
         state_r == nv_trim_pkg::S_PULSE && active_r
         && attempt_r == $past(attempt_r) + 1'b1;
   endproperty
   a_retry: assert property (p_retry) // see [RULE3]
      else $error("failed attempt not retried");

   property p_trim_math;
      ##1 effectivePotValue == ($past(trim_r[nv_trim_pkg::TRIM_SIGN_BIT])
         ? $past(pot_r) - $past(trimMag) : $past(pot_r) + $past(trimMag));
   endproperty
   a_trim_math: assert property (p_trim_math) // see [RULE6]
      else $error("effective pot value wrong");

   property p_exclusive;
      !(busy && dispEn_r) and (launchReq && dispEn_r |=> !active_r);
   endproperty
   a_exclusive: assert property (p_exclusive) // see [RULE7]
      else $error("nv operation and display overlap");

   property p_mask_load;
      paramOk && pendCmd_r == nv_trim_pkg::CMD_NV_MASK |=>
         mask_r == $past(hostWrData) && !pendValid_r;
   endproperty
   a_mask_load: assert property (p_mask_load) // see [RULE10]
      else $error("mask byte not taken");

   property p_auto_settle;
      state_r == nv_trim_pkg::S_AUTO_SETTLE |-> active_r && ok_r;
   endproperty
   a_auto_settle: assert property (p_auto_settle) // see [RULE20]
      else $error("auto read flags not 11 while settling");

   property p_swreset_no_read;
      swReset |=> state_r != nv_trim_pkg::S_AUTO_START
         && state_r != nv_trim_pkg::S_AUTO_SENSE;
   endproperty
   a_swreset_no_read: assert property (p_swreset_no_read) // see [RULE19]
      else $error("software reset started an auto read");

   c_auto_done: cover property (state_r == nv_trim_pkg::S_AUTO_SETTLE
      ##1 state_r == nv_trim_pkg::S_IDLE);
   c_retry: cover property (state_r == nv_trim_pkg::S_CHECK && !verifyPass
      && attempt_r == '0);
   c_abort: cover property (state_r == nv_trim_pkg::S_CHECK && !verifyPass
      && attempt_r == nv_trim_pkg::LAST_ATTEMPT);
   c_launch_blocked: cover property (launchReq && dispEn_r);
endmodule
`default_nettype wire

/* File: tb/nv_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module nv_host_model (
   input  wire logic       ref_clk,
   input  wire logic       hostRdValid,
   input  wire logic [7:0] hostRdData,
   output logic            hostStrobe,
   output logic            cmdDataSelect,
   output logic            readWriteSelect,
   output logic      [7:0] hostWrData
);
   initial begin
      hostStrobe      = 1'h0;
      cmdDataSelect   = 1'h0;
      readWriteSelect = 1'h0;
      hostWrData      = 8'h00;
   end
   // one strobe per host cycle, changed on the falling edge
   task automatic send(input logic cd, input logic rw, input logic [7:0] b);
      @(negedge ref_clk);
      hostStrobe      = 1'h1;
      cmdDataSelect   = cd;
      readWriteSelect = rw;
      hostWrData      = b;
      @(negedge ref_clk);
      hostStrobe = 1'h0;
      // no pull on the bus, so an idle byte must not repeat the last one
      hostWrData = ~b;
   endtask
   task automatic write_cmd(input logic [7:0] b);
      send(1'h0, 1'h0, b);
   endtask
   task automatic read_status(output logic [7:0] b, output logic v);
      send(1'h0, 1'h1, 8'h00);
      v = hostRdValid;
      b = hostRdData;
   endtask
endmodule
`default_nettype wire

/* File: tb/nv_trim_program_erase_ctrl_test.sv */
`timescale 1ns/1ns
`default_nettype none
module nv_trim_program_erase_ctrl_test;
   localparam logic VARIANT = 1'h0; // arbitrary value
   localparam logic [7:0] WR_V = nv_trim_pkg::WR_VOLT_RESET;
   localparam logic [7:0] RD_V = nv_trim_pkg::RD_VOLT_RESET;
   logic       ref_clk;
   logic       reset_n;
   logic       supplyPin;
   logic       hostStrobe;
   logic       cmdDataSelect;
   logic       readWriteSelect;
   logic [7:0] hostWrData;
   logic [7:0] hostRdData;
   logic       hostRdValid;
   logic       displayEnable;
   logic [7:0] effectivePotValue;
   logic [5:0] trimOffsetField;
   logic [7:0] pumpVoltageSetting;
   logic       nvOpActive;
   logic       verifyOk;
   int         failures;
   int         numChecks;
   int         cycles;

   nv_trim_program_erase_ctrl #(.TICK_CYCLES(4), .VARIANT_ID(VARIANT)) i_dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .hostStrobe(hostStrobe),
      .cmdDataSelect(cmdDataSelect), .readWriteSelect(readWriteSelect),
      .hostWrData(hostWrData), .programSupplyPin(supplyPin),
      .hostRdData(hostRdData), .hostRdValid(hostRdValid),
      .displayEnable(displayEnable), .effectivePotValue(effectivePotValue),
      .trimOffsetField(trimOffsetField),
      .pumpVoltageSetting(pumpVoltageSetting),
      .nvOpActive(nvOpActive), .verifyOk(verifyOk));

   nv_host_model host (
      .ref_clk(ref_clk), .hostRdValid(hostRdValid), .hostRdData(hostRdData),
      .hostStrobe(hostStrobe), .cmdDataSelect(cmdDataSelect),
      .readWriteSelect(readWriteSelect), .hostWrData(hostWrData));

   initial begin
      ref_clk = 1'h0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // whole run needs about 650 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         $display("ERROR %0t timeout", $time);
         print_verdict();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string msg);
      numChecks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic chk_rng(input int n, input int lo, input int hi);
      numChecks++;
      if (n < lo || n > hi) begin
         failures++;
         $display("ERROR %0t duration %0d not in %0d..%0d", $time, n, lo, hi);
      end
   endtask
   function automatic logic [7:0] stat(input logic a, input logic o);
      stat = {5'h00, o, VARIANT, a};
   endfunction
   task automatic settle;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic wait_flags(input logic [1:0] f, input int lim, output int n);
      n = 0;
      while ({nvOpActive, verifyOk} !== f && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      chk({6'h00, nvOpActive, verifyOk}, {6'h00, f}, "flag pair");
   endtask
   task automatic do_reset;
      @(negedge ref_clk);
      reset_n = 1'h0;
      repeat (12) @(negedge ref_clk);
      reset_n = 1'h1;
   endtask

   task automatic t_auto_read;
      int n;
      wait_flags(2'h2, 20, n);
      wait_flags(2'h3, 20, n);
      chk_rng(n, 7, 9);
      wait_flags(2'h1, 20, n);
      chk_rng(n, 7, 9);
      chk({2'h0, trimOffsetField}, 8'h00, "trim");
      chk(effectivePotValue, nv_trim_pkg::POT_RESET, "pot");
   endtask
   task automatic t_status;
      logic [7:0] b;
      logic       v;
      host.read_status(b, v);
      chk({7'h00, v}, 8'h01, "read valid");
      chk(b, stat(1'h0, 1'h1), "status");
   endtask
   task automatic t_display;
      host.write_cmd(nv_trim_pkg::CMD_BIAS_POT);
      // a data cycle between opcode and parameter must not be taken
      host.send(1'h1, 1'h0, 8'h77);
      host.write_cmd(8'h30);
      settle();
      chk(effectivePotValue, 8'h30, "pot with zero trim");
      host.write_cmd(nv_trim_pkg::CMD_NV_CONTROL);
      host.write_cmd(8'h02); // no launch bit
      settle();
      chk({7'h00, nvOpActive}, 8'h00, "launch bit clear");
      host.write_cmd(nv_trim_pkg::CMD_DISP_ON);
      settle();
      chk({7'h00, displayEnable}, 8'h01, "display on");
      host.write_cmd(nv_trim_pkg::CMD_NV_CONTROL);
      host.write_cmd(8'h0A);
      host.write_cmd(nv_trim_pkg::CMD_SW_RESET);
      settle();
      chk({7'h00, nvOpActive}, 8'h00, "launch while on");
      host.write_cmd(nv_trim_pkg::CMD_DISP_OFF);
      settle();
      chk({7'h00, displayEnable}, 8'h00, "display off");
      chk(effectivePotValue, 8'h30, "pot kept");
      chk({6'h00, nvOpActive, verifyOk}, 8'h01, "auto read");
   endtask
   task automatic t_launch(input logic [7:0] wt, input logic [7:0] msk,
                           input logic [2:0] op);
      host.write_cmd(nv_trim_pkg::CMD_WR_TIMER);
      host.write_cmd(wt);
      host.write_cmd(nv_trim_pkg::CMD_NV_MASK);
      host.write_cmd(msk);
      host.write_cmd(nv_trim_pkg::CMD_NV_CONTROL);
      host.write_cmd({4'h0, 1'h1, op});
   endtask
   task automatic t_erase(input logic [7:0] wt, input int lo, input int hi);
      logic [7:0] b;
      logic       v;
      int         n;
      t_launch(wt, 8'h0F, nv_trim_pkg::OP_ERASE);
      host.read_status(b, v);
      chk(b, stat(1'h1, 1'h0), "busy status");
      chk(pumpVoltageSetting, WR_V, "pump in pulse");
      host.write_cmd(nv_trim_pkg::CMD_DISP_ON);
      wait_flags(2'h1, 300, n);
      chk_rng(n, lo, hi);
      chk({7'h00, displayEnable}, 8'h00, "display while busy");
      chk(pumpVoltageSetting, RD_V, "pump idle");
      host.read_status(b, v);
      chk(b, stat(1'h0, 1'h1), "erase passed");
   endtask
   task automatic t_program(input logic sup, input logic [1:0] f,
                            input int lo, input int hi);
      int n;
      supplyPin = sup;
      settle();
      t_launch(8'h02, 8'h01, nv_trim_pkg::OP_PROGRAM);
      wait_flags(2'h2, 4, n);
      wait_flags(f, 400, n);
      chk_rng(n, lo, hi);
   endtask

   initial begin
      reset_n   = 1'h0;
      supplyPin = 1'h0;
      failures  = 0;
      numChecks = 0;
      cycles    = 0;
      do_reset();
      t_auto_read();
      t_status();
      t_display();
      t_erase(8'h02, 80, 92);
      t_erase(8'h01, 40, 52);
      t_program(1'h0, 2'h0, 255, 272);
      t_program(1'h1, 2'h1, 80, 95);
      // reset pulse before power down, then the auto read runs again
      do_reset();
      t_auto_read();
      print_verdict();
   end
endmodule
`default_nettype wire
